/* File: msb_bridge.sv */
// Backplane port core of the multidrop scan bridge
// Contract
// - Sixteen-state TAP controller governs the device
// - IR and data registers capture, shift, update
// - Scanned address matching slot selects device
// - Network multiplexes ports into the chain
// - Per-port controller from IR, mode, TAP
// - Each port drives clock, mode, data, reset
// - Backplane mode input sequences all controllers
// - Scan data enters only on backplane input
// - Backplane output returns own and ring data
// - Backplane test clock times every operation
// - Low test reset initializes asynchronously
// - Notifier high while its data output floats
// - Pass input goes to single selected port
// - Pass output comes from single selected port
// - No pass-through with several ports selected
// - Unselected device ignores all but its slot address
// - Pad bit captures local input on falling edge
// - Parked port holds its mode output constant
// - Output enable high floats all local outputs
`timescale 1ns/1ns
`include "msb_cfg.svh"
module msb_bridge
    import msb_pkg::*;
#(
    parameter int NPORTS = 3,
    parameter int NPT    = 2
) (
    input  wire logic                    mclk,         // Backplane test clock
    input  wire logic                    trst_n,       // Backplane reset, low
    input  wire logic                    ce,           // Clock enable
    input  wire logic                    tms_b,        // Backplane mode select
    input  wire logic                    tdi_b,        // Backplane data in
    output logic                         tdo_b,        // Backplane data out
    output logic                         tdo_b_oe,     // Backplane out drive
    output logic                         hiz_notify_b, // Backplane out floats
    input  wire logic [`MSB_SLOT_W-1:0]  slot_id,      // Slot address straps
    input  wire logic                    lsp_oe_n,     // Local enable, low
    output msb_lsp_s [NPORTS-1:0]        lsp_out,      // Local port signals
    output logic [NPORTS-1:0]            lsp_out_oe,   // Local port drive
    input  wire logic [NPORTS-1:0]       lsp_tdi,      // Local data in
    output logic [NPORTS-1:0]            hiz_notify_out, // Local out floats
    input  wire logic                    a_b,          // Backplane pass in
    output logic                         y_b,          // Backplane pass out
    input  wire logic [NPT-1:0]          pt_a,         // Local pass in
    output logic [NPT-1:0]               pt_y,         // Local pass out
    output logic                         selected,     // Device addressed
    output logic [`MSB_USER_W-1:0]       user_data,    // Scanned user word
    output logic                         user_valid,   // User word present
    input  wire logic                    user_ready    // User word taken
);
    // Chain counter and pass-through decode serve one to three ports
    if (NPORTS < 1 || NPORTS > 3 || NPT < 1 || NPT > NPORTS) begin : g_bad
        $error("msb_bridge: unsupported port counts");
    end

    msb_tap_e                 st_q, st_d;
    logic [`MSB_IR_W-1:0]     ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic                     sel_q, sel_d;
    logic                     byp_q, byp_d;
    logic [2:0]               mode_sh_q, mode_sh_d, mode_q, mode_d;
    logic [`MSB_USER_W-1:0]   usr_sh_q, usr_sh_d;
    logic [NPORTS-1:0]        unp_q, unp_d;
    logic [NPORTS-1:0]        pad_q;
    logic                     oe_s1_q, oe_s2_q, oe_s3_q, oe_f_q, oe_f_d;
    logic                     tdo_q, tdo_oe_q;
    logic                     dev_so, chain_so, single, fifo_rdy, push;
    logic [NPORTS-1:0]        ltdo;
    logic [1:0]               nunp;

    // Central TAP controller next state
    always_comb begin
        case (st_q)
            MSB_TLR:  st_d = tms_b ? MSB_TLR  : MSB_RTI;
            MSB_RTI:  st_d = tms_b ? MSB_SDRS : MSB_RTI;
            MSB_SDRS: st_d = tms_b ? MSB_SIRS : MSB_CDR;
            MSB_CDR:  st_d = tms_b ? MSB_E1DR : MSB_SDR;
            MSB_SDR:  st_d = tms_b ? MSB_E1DR : MSB_SDR;
            MSB_E1DR: st_d = tms_b ? MSB_UDR  : MSB_PDR;
            MSB_PDR:  st_d = tms_b ? MSB_E2DR : MSB_PDR;
            MSB_E2DR: st_d = tms_b ? MSB_UDR  : MSB_SDR;
            MSB_UDR:  st_d = tms_b ? MSB_SDRS : MSB_RTI;
            MSB_SIRS: st_d = tms_b ? MSB_TLR  : MSB_CIR;
            MSB_CIR:  st_d = tms_b ? MSB_E1IR : MSB_SIR;
            MSB_SIR:  st_d = tms_b ? MSB_E1IR : MSB_SIR;
            MSB_E1IR: st_d = tms_b ? MSB_UIR  : MSB_PIR;
            MSB_PIR:  st_d = tms_b ? MSB_E2IR : MSB_PIR;
            MSB_E2IR: st_d = tms_b ? MSB_UIR  : MSB_SIR;
            MSB_UIR:  st_d = tms_b ? MSB_SDRS : MSB_RTI;
            default:  st_d = MSB_TLR;
        endcase
    end

    // Instruction path and level-1 addressing
    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        sel_d   = sel_q;
        case (st_q)
            MSB_TLR: begin
                ir_d  = `MSB_IR_RESET;
                sel_d = 1'b0;
            end
            MSB_CIR: ir_sh_d = `MSB_IR_CAPTURE;
            MSB_SIR: ir_sh_d = {tdi_b, ir_sh_q[`MSB_IR_W-1:1]};
            MSB_UIR: begin
                if (!sel_q) begin
                    // Only an address is honoured while unselected
                    if (ir_sh_q[`MSB_SLOT_W-1:0] == slot_id) begin
                        sel_d = 1'b1;
                        ir_d  = `MSB_INS_BYPASS;
                    end
                end else if (ir_sh_q == `MSB_INS_WAIT) begin
                    sel_d = 1'b0;
                    ir_d  = `MSB_INS_BYPASS;
                end else begin
                    ir_d = ir_sh_q;
                end
            end
            default: ;
        endcase
    end

    // Data registers; unselected device shifts bypass but updates neither mode nor user word
    always_comb begin
        byp_d     = byp_q;
        mode_sh_d = mode_sh_q;
        mode_d    = mode_q;
        usr_sh_d  = usr_sh_q;
        push      = 1'b0;
        case (st_q)
            MSB_TLR: mode_d = `MSB_MODE_RESET;
            MSB_CDR: begin
                byp_d     = 1'b0;
                mode_sh_d = mode_q;
                usr_sh_d  = {{(`MSB_USER_W-1){1'b0}}, !fifo_rdy};
            end
            MSB_SDR: begin
                byp_d = tdi_b;
                if (sel_q && ir_q == `MSB_INS_MODE)
                    mode_sh_d = {tdi_b, mode_sh_q[2:1]};
                if (sel_q && ir_q == `MSB_INS_USER)
                    usr_sh_d = {tdi_b, usr_sh_q[`MSB_USER_W-1:1]};
            end
            MSB_UDR: begin
                if (sel_q && ir_q == `MSB_INS_MODE) mode_d = mode_sh_q;
                // A full buffer drops the word; capture reports it
                push = sel_q && ir_q == `MSB_INS_USER && fifo_rdy;
            end
            default: ;
        endcase
    end

    // Local port controllers: park or unpark on entry to idle
    always_comb begin
        unp_d = unp_q;
        if (st_q == MSB_TLR || !sel_q) begin
            unp_d = '0;
        end else if (st_q == MSB_UIR && !tms_b) begin
            if (ir_sh_q == `MSB_INS_PARK)   unp_d = '0;
            if (ir_sh_q == `MSB_INS_UNPARK) unp_d = mode_q[NPORTS-1:0];
        end
    end

    // Output enable pin filter: accept once two later stages agree
    always_comb begin
        oe_f_d = (oe_s2_q == oe_s3_q) ? oe_s3_q : oe_f_q;
    end

    // Rising-edge state, async reset by backplane reset
    always_ff @(posedge mclk or negedge trst_n) begin
        if (!trst_n) begin
            st_q      <= MSB_TLR;
            ir_sh_q   <= '0;
            ir_q      <= `MSB_IR_RESET;
            sel_q     <= 1'b0;
            byp_q     <= 1'b0;
            mode_sh_q <= '0;
            mode_q    <= `MSB_MODE_RESET;
            usr_sh_q  <= '0;
            unp_q     <= '0;
            oe_s1_q   <= 1'b1;
            oe_s2_q   <= 1'b1;
            oe_s3_q   <= 1'b1;
            oe_f_q    <= 1'b1;
        end else if (ce) begin
            st_q      <= st_d;
            ir_sh_q   <= ir_sh_d;
            ir_q      <= ir_d;
            sel_q     <= sel_d;
            byp_q     <= byp_d;
            mode_sh_q <= mode_sh_d;
            mode_q    <= mode_d;
            usr_sh_q  <= usr_sh_d;
            unp_q     <= unp_d;
            oe_s1_q   <= lsp_oe_n;
            oe_s2_q   <= oe_s1_q;
            oe_s3_q   <= oe_s2_q;
            oe_f_q    <= oe_f_d;
        end
    end

    // Serial source of the bridge's own current register
    always_comb begin
        if (st_q == MSB_SIR)                       dev_so = ir_sh_q[0];
        else if (sel_q && ir_q == `MSB_INS_MODE)   dev_so = mode_sh_q[0];
        else if (sel_q && ir_q == `MSB_INS_USER)   dev_so = usr_sh_q[0];
        else                                       dev_so = byp_q;
    end

    // Chain: bridge register, then each unparked ring and its pad
    always_comb begin
        chain_so = dev_so;
        nunp     = '0;
        for (int k = 0; k < NPORTS; k++) begin
            ltdo[k] = chain_so;
            if (unp_q[k]) begin
                chain_so = pad_q[k];
                nunp     = nunp + 2'd1;
            end
        end
    end

    // Pad bits retime the returning ring data on the falling edge
    always_ff @(negedge mclk or negedge trst_n) begin
        if (!trst_n) begin
            pad_q    <= '0;
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (ce) begin
            pad_q    <= lsp_tdi;
            tdo_q    <= chain_so;
            tdo_oe_q <= sel_q && (st_q == MSB_SIR || st_q == MSB_SDR);
        end
    end

    assign tdo_b        = tdo_q;
    assign tdo_b_oe     = tdo_oe_q;
    assign hiz_notify_b = !tdo_oe_q;
    assign selected     = sel_q;

    // Local port pins; parked ports see a steady low mode select
    always_comb begin
        for (int k = 0; k < NPORTS; k++) begin
            lsp_out[k].tck    = mclk;
            lsp_out[k].tms    = unp_q[k] ? tms_b : 1'b0;
            lsp_out[k].tdo    = ltdo[k];
            lsp_out[k].trst_n = trst_n;
            lsp_out_oe[k]     = !oe_f_q;
            hiz_notify_out[k] = oe_f_q;
        end
    end

    // Pass-through works only with exactly one port unparked
    always_comb begin
        single = nunp == 2'd1;
        y_b    = 1'b0;
        for (int k = 0; k < NPT; k++) begin
            pt_y[k] = single && unp_q[k] && a_b;
            if (single && unp_q[k]) y_b = pt_a[k];
        end
    end

    msb_fifo #(
        .W (`MSB_USER_W),
        .D (`MSB_FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rst_n     (trst_n),
        .ce        (ce),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .in_data   (usr_sh_q),
        .out_valid (user_valid),
        .out_ready (user_ready),
        .out_data  (user_data)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!trst_n);

    sequence s_tms_high5;
        (ce && tms_b) [*5];
    endsequence
    sequence s_addr_update;
        ce && st_q == MSB_UIR && !sel_q && ir_sh_q[6:0] == slot_id;
    endsequence

    a_tap_reset_five: assert property (s_tms_high5 |=> st_q == MSB_TLR)
        else $error("TAP not in reset after five high mode bits");
    a_ir_capture: assert property (ce && st_q == MSB_CIR |=>
        ir_sh_q == `MSB_IR_CAPTURE)
        else $error("IR capture value wrong");
    a_addr_select: assert property (s_addr_update |=> sel_q)
        else $error("Matching address did not select");
    a_unsel_parked: assert property (!sel_q |-> !push &&
        ($past(sel_q) || unp_q == '0))
        else $error("Unselected device reached data or ports");
    a_pass_multi: assert property (nunp > 2'd1 |-> !y_b && pt_y == '0)
        else $error("Pass-through active with several ports");
    a_pass_fwd: assert property (single && unp_q[0] |->
        pt_y[0] == a_b && y_b == pt_a[0])
        else $error("Pass-through not forwarded");
    a_park_tms: assert property (!unp_q[0] |-> !lsp_out[0].tms)
        else $error("Parked port mode select moved");
    a_local_hiz: assert property (oe_f_q |-> lsp_out_oe == '0 &&
        hiz_notify_out == '1)
        else $error("Local outputs driven while disabled");
    a_tdo_notify: assert property (hiz_notify_b == !tdo_b_oe &&
        (!tdo_b_oe || sel_q))
        else $error("Backplane notifier mismatch");
endmodule : msb_bridge

/* File: msb_cfg.svh */
// Constants of the multidrop scan bridge backplane port
`ifndef MSB_CFG_SVH
`define MSB_CFG_SVH
`define MSB_IR_W        8
`define MSB_SLOT_W      7
`define MSB_IR_CAPTURE  8'h01
`define MSB_IR_RESET    8'hFF
`define MSB_INS_BYPASS  8'hFF
`define MSB_INS_MODE    8'h81
`define MSB_INS_PARK    8'h82
`define MSB_INS_UNPARK  8'h83
`define MSB_INS_USER    8'h84
`define MSB_INS_WAIT    8'h85
`define MSB_MODE_RESET  3'h0
`define MSB_USER_W      16
`define MSB_FIFO_DEPTH  16
`endif

/* File: msb_fifo.sv */
// Word FIFO with registered read data
`timescale 1ns/1ns
module msb_fifo
    import msb_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         clk,       // Clock
    input  wire logic         rst_n,     // Async reset, low
    input  wire logic         ce,        // Clock enable
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Room for a word
    input  wire logic [W-1:0] in_data,   // Write word
    output logic              out_valid, // Read word present
    input  wire logic         out_ready, // Reader takes word
    output logic [W-1:0]      out_data   // Read word, registered
);
    localparam int AW = $clog2(D);
    // Pointer wrap relies on a power-of-two depth
    if (D < 2 || (1 << AW) != D) begin : g_bad
        $error("msb_fifo: D power of two >= 2");
    end

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ov_q, ov_d;
    logic [W-1:0]  od_q, od_d;
    logic          push, pop;

    // Output stage refills whenever it is empty or being taken
    always_comb begin
        push     = in_valid && (cnt_q != (AW+1)'(D));
        pop      = (cnt_q != '0) && (!ov_q || out_ready);
        in_ready = cnt_q != (AW+1)'(D);
        wr_d     = push ? wr_q + 1'b1 : wr_q;
        rd_d     = pop ? rd_q + 1'b1 : rd_q;
        cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        ov_d     = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d     = pop ? mem_q[rd_q] : od_q;
    end

    // Storage holds no reset; only pointers, count and output stage need defined values
    always_ff @(posedge clk) begin
        if (ce && push) mem_q[wr_q] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else if (ce) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    assign out_valid = ov_q;
    assign out_data  = od_q;
endmodule : msb_fifo

/* File: msb_master_model.sv */
// Backplane scan master model that drives the bridge test port
`timescale 1ns/1ns
module msb_master_model (
    input  wire logic mclk,     // Backplane test clock
    input  wire logic tdo_b,    // Bridge data out
    input  wire logic tdo_b_oe, // Bridge out drive
    output logic      tms_b,    // Mode select to bridge
    output logic      tdi_b     // Scan data to bridge
);
    // Idle levels follow the pull-ups on both inputs
    initial begin
        tms_b = 1'b1;
        tdi_b = 1'b1;
    end

    // One cycle: read the falling-edge output, then present new levels
    task automatic step(input logic t, input logic d, output logic o,
                        output logic e);
        @(posedge mclk);
        // A released line reads inverted, so a float never passes as data
        o = tdo_b_oe ? tdo_b : ~tdo_b;
        e = tdo_b_oe;
        tms_b <= t;
        tdi_b <= d;
    endtask : step

    // Stay in Run-Test/Idle, finish where outputs are settled
    task automatic idle(input int n);
        logic o, e;
        for (int i = 0; i < n; i++) step(1'b0, 1'b1, o, e);
        @(negedge mclk);
    endtask : idle

    // Full IR or DR scan from Run-Test/Idle back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout, output logic oe_all,
                        output logic oe_any);
        logic o, e;
        dout   = '0;
        oe_all = 1'b1;
        oe_any = 1'b0;
        step(1'b1, 1'b1, o, e);
        if (ir) step(1'b1, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        // Last bit leaves Shift, the extra pass enters Update
        for (int i = 0; i <= n; i++) begin
            step(i >= n - 1, (i < n) ? din[i] : 1'b1, o, e);
            if (i > 0) begin
                dout[i-1] = o;
                oe_all    = oe_all & e;
                oe_any    = oe_any | e;
            end
        end
        step(1'b0, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        @(negedge mclk);
    endtask : scan
endmodule : msb_master_model

/* File: msb_pkg.sv */
// Types of the multidrop scan bridge backplane port
package msb_pkg;
    typedef enum logic [3:0] {
        MSB_TLR  = 4'b0000,
        MSB_RTI  = 4'b0001,
        MSB_SDRS = 4'b0010,
        MSB_CDR  = 4'b0011,
        MSB_SDR  = 4'b0100,
        MSB_E1DR = 4'b0101,
        MSB_PDR  = 4'b0110,
        MSB_E2DR = 4'b0111,
        MSB_UDR  = 4'b1000,
        MSB_SIRS = 4'b1001,
        MSB_CIR  = 4'b1010,
        MSB_SIR  = 4'b1011,
        MSB_E1IR = 4'b1100,
        MSB_PIR  = 4'b1101,
        MSB_E2IR = 4'b1110,
        MSB_UIR  = 4'b1111
    } msb_tap_e;
    // Three scan signals plus local reset of one local_scan_port
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdo;
        logic trst_n;
    } msb_lsp_s;
endpackage : msb_pkg

/* File: multidrop_scan_bridge_backplane_port_tb.sv */
// Self-checking bench of the scan bridge backplane port
`timescale 1ns/1ns
`include "msb_cfg.svh"
module multidrop_scan_bridge_backplane_port_tb
    import msb_pkg::*;
;
    logic        mclk, trst_n, a_b, lsp_oe_n, user_ready, chk_tms;
    logic [6:0]  slot_id;
    logic [1:0]  pt_a, pt_y;
    logic        tms_b, tdi_b, tdo_b, tdo_b_oe, hiz_notify_b, y_b;
    logic        selected, user_valid, oa, on, so, se;
    msb_lsp_s [2:0] lsp_out;
    logic [2:0]  lsp_out_oe, lsp_tdi, hiz_notify_out;
    logic [15:0] user_data, w, d;
    logic [15:0] exp_q[$];
    int          error_cnt, check_count;
    integer      seed = 32'h9a22_6467;

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // Zero-length rings; a floating port line toggles instead
    always_comb begin
        for (int k = 0; k < 3; k++)
            lsp_tdi[k] = lsp_out_oe[k] ? lsp_out[k].tdo : mclk;
    end

    msb_bridge uut (
        .mclk(mclk), .trst_n(trst_n), .ce(1'b1), .tms_b(tms_b),
        .tdi_b(tdi_b), .tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe),
        .hiz_notify_b(hiz_notify_b), .slot_id(slot_id),
        .lsp_oe_n(lsp_oe_n), .lsp_out(lsp_out), .lsp_out_oe(lsp_out_oe),
        .lsp_tdi(lsp_tdi), .hiz_notify_out(hiz_notify_out), .a_b(a_b),
        .y_b(y_b), .pt_a(pt_a), .pt_y(pt_y), .selected(selected),
        .user_data(user_data), .user_valid(user_valid),
        .user_ready(user_ready)
    );

    msb_master_model m (
        .mclk(mclk), .tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe),
        .tms_b(tms_b), .tdi_b(tdi_b)
    );

    task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : check

    task automatic summarize();
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // Oldest noted word against each word the user side takes
    always @(posedge mclk) begin
        if (user_valid === 1'b1 && user_ready === 1'b1) begin
            if (exp_q.size() == 0) check("user_extra", 16'h0000, 16'h0001);
            else check("user_data", exp_q.pop_front(), user_data);
        end
    end

    // Local port lines mid-cycle, away from both clock edges
    always @(negedge mclk) begin
        #5;
        if (chk_tms) begin
            check("tms0", tms_b, lsp_out[0].tms);
            check("tms2", 1'b0, lsp_out[2].tms);
            check("tck0", mclk, lsp_out[0].tck);
            check("trst0", trst_n, lsp_out[0].trst_n);
        end
    end

    // Hang guard, far above the length of the sequence
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        summarize();
    end

    initial begin
        trst_n = 1'b0; a_b = 1'b0; pt_a = 2'b00; lsp_oe_n = 1'b1;
        user_ready = 1'b0; chk_tms = 1'b0;
        slot_id = 7'($random(seed)) | 7'h01;
        repeat (2) @(posedge mclk);
        trst_n <= 1'b1;
        check("hiz_b", 1'b1, hiz_notify_b);
        check("oe_b", 1'b0, tdo_b_oe);
        check("sel_rst", 1'b0, selected);
        lsp_oe_n <= 1'b0;
        m.idle(6);
        check("lsp_oe", 3'b111, lsp_out_oe);
        check("hiz_out", 3'b000, hiz_notify_out);
        // Foreign address first: stays unselected and silent
        m.scan(1'b1, 8, {9'h000, ~slot_id}, d, oa, on);
        check("sel_bad", 1'b0, selected);
        check("oe_unsel", 1'b0, on);
        m.scan(1'b1, 8, {9'h000, slot_id}, d, oa, on);
        check("sel_ok", 1'b1, selected);
        m.scan(1'b1, 8, {8'h00, `MSB_INS_BYPASS}, d, oa, on);
        check("ir_cap", `MSB_IR_CAPTURE, d[7:0]);
        check("oe_shift", 1'b1, oa);
        // Fill the word buffer past full with nobody taking words
        m.scan(1'b1, 8, {8'h00, `MSB_INS_USER}, d, oa, on);
        for (int k = 0; k < 18; k++) begin
            w = 16'($random(seed));
            m.scan(1'b0, 16, w, d, oa, on);
            if (k < 17) exp_q.push_back(w);
            if (k == 0 || k == 17) check("full_bit", k == 17, d[0]);
        end
        // Drain with a stalling reader
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) begin
            @(posedge mclk);
            user_ready <= 1'($random(seed));
        end
        if (exp_q.size() > 0) begin
            error_cnt++;
            summarize();
        end
        @(posedge mclk);
        user_ready <= 1'b1;
        m.idle(3);
        check("drained", 1'b0, user_valid);
        // Unpark port 0 alone
        m.scan(1'b1, 8, {8'h00, `MSB_INS_MODE}, d, oa, on);
        m.scan(1'b0, 3, 16'h0001, d, oa, on);
        m.scan(1'b1, 8, {8'h00, `MSB_INS_UNPARK}, d, oa, on);
        @(posedge mclk);
        chk_tms <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk);
            a_b  <= v[0];
            pt_a <= {v[0], ~v[0]};
            @(negedge mclk);
            check("pt_y0", v[0], pt_y[0]);
            check("y_b", !v[0], y_b);
        end
        // Extra leading bit covers the ring and pad in the chain
        m.scan(1'b1, 9, {7'h00, `MSB_INS_BYPASS, 1'b1}, d, oa, on);
        w = 16'($random(seed));
        m.scan(1'b0, 8, w, d, oa, on);
        check("chain", w[5:0], d[7:2]);
        @(posedge mclk);
        chk_tms <= 1'b0;
        m.scan(1'b1, 9, {7'h00, `MSB_INS_WAIT, 1'b1}, d, oa, on);
        check("sel_wait", 1'b0, selected);
        // Two ports unparked: pass-through must go quiet
        m.scan(1'b1, 8, {9'h000, slot_id}, d, oa, on);
        m.scan(1'b1, 8, {8'h00, `MSB_INS_MODE}, d, oa, on);
        m.scan(1'b0, 3, 16'h0003, d, oa, on);
        @(posedge mclk);
        a_b  <= 1'b1;
        pt_a <= 2'b11;
        m.scan(1'b1, 8, {8'h00, `MSB_INS_UNPARK}, d, oa, on);
        check("pt_multi", 2'b00, pt_y);
        check("y_multi", 1'b0, y_b);
        // Park both; the next IR scan must see no pad bits in the chain
        m.scan(1'b1, 8, {8'h00, `MSB_INS_PARK}, d, oa, on);
        m.scan(1'b1, 8, {8'h00, `MSB_INS_BYPASS}, d, oa, on);
        check("ir_parked", `MSB_IR_CAPTURE, d[7:0]);
        @(posedge mclk);
        lsp_oe_n <= 1'b1;
        m.idle(6);
        check("lsp_off", 3'b000, lsp_out_oe);
        check("hiz_off", 3'b111, hiz_notify_out);
        // Five high mode bits reach reset and drop the selection
        repeat (5) m.step(1'b1, 1'b1, so, se);
        m.idle(2);
        check("sel_tlr", 1'b0, selected);
        m.scan(1'b1, 8, {9'h000, slot_id}, d, oa, on);
        check("sel_again", 1'b1, selected);
        // Reset between edges must act at once
        @(posedge mclk);
        trst_n <= 1'b0;
        #5;
        check("sel_async", 1'b0, selected);
        check("hiz_async", 1'b1, hiz_notify_b);
        summarize();
    end
endmodule : multidrop_scan_bridge_backplane_port_tb
